/* pkg/clkd_params.svh */
// Constants for the clock divider control block
`ifndef CLKD_PARAMS_SVH
`define CLKD_PARAMS_SVH

// ----------------------------------------
// Word widths
// ----------------------------------------
`define CLKD_WORD_W        9
`define CLKD_SHIFT_W       18

// ----------------------------------------
// Mode word field positions
// ----------------------------------------
`define CLKD_REF_SRC_BIT   0
`define CLKD_BYP_ALL_BIT   1
`define CLKD_PRE_BYP_BIT   2
`define CLKD_PRE_RAT_BIT   3
`define CLKD_PIN_FN_BIT    4
`define CLKD_TAP_DIS_BIT   5

// ----------------------------------------
// Factory contents of the stored words, and the divider offset
// ----------------------------------------
`define CLKD_MODE_DEFAULT  9'h010
`define CLKD_RATIO_DEFAULT 9'h000
`define CLKD_DIV_OFFSET    2

`endif

/* pkg/clkd_pkg.sv */
// Types for the clock divider control block
package clkd_pkg;

    // ----------------------------------------
    // Mode word layout
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] zero_bits;
        logic       tap_dis;
        logic       pin_func;
        logic       pre_ratio;
        logic       pre_byp;
        logic       byp_all;
        logic       ref_src;
    } clkd_mode_t;

    typedef struct packed {
        clkd_mode_t mode;
        logic [8:0] ratio;
    } clkd_cfg_t;

    // ----------------------------------------
    // State machines
    // ----------------------------------------
    typedef enum logic [3:0] {
        CLKD_ST_STRAP = 4'h1,
        CLKD_ST_LOAD  = 4'h2,
        CLKD_ST_PROG  = 4'h4,
        CLKD_ST_RUN   = 4'h8
    } clkd_state_t;

    typedef enum logic [3:0] {
        CLKD_PW_ON   = 4'h1,
        CLKD_PW_GATE = 4'h2,
        CLKD_PW_TAP  = 4'h4,
        CLKD_PW_OFF  = 4'h8
    } clkd_pwr_t;

endpackage : clkd_pkg

/* design/clkd_prescaler.sv */
// Divide-by-2 or divide-by-4 prescaler on a sampled clock level
`timescale 1ns/1ps
module clkd_prescaler (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic clk_in,
    input  wire logic div2,
    output logic      clk_out
);
    logic in_d_r;
    logic half_r;

    // ----------------------------------------
    // Edge detect and toggle
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_d_r  <= 1'b0;
            half_r  <= 1'b0;
            clk_out <= 1'b0;
        end
        else if (clk_en)
        begin
            in_d_r <= clk_in;
            if (clk_in && !in_d_r)
            begin
                half_r <= ~half_r;
                if (div2 || half_r)
                    clk_out <= ~clk_out;
            end
        end
    end

endmodule : clkd_prescaler

/* design/clkd_divider.sv */
// Programmable divide-by-(ratio+2) counter with synchronous clear
`timescale 1ns/1ps
`include "clkd_params.svh"
module clkd_divider #(
    parameter int RW = `CLKD_WORD_W
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    input  wire logic          clk_en,
    input  wire logic          clk_in,
    input  wire logic          clr,
    input  wire logic [RW-1:0] ratio,
    output logic               div_out
);
    logic          in_d_r;
    logic          idle_r;
    logic [RW:0]   cnt_r;
    logic [RW:0]   cnt_nxt;
    logic [RW:0]   div_len;
    logic [RW:0]   hi_len;

    assign div_len = {1'b0, ratio} + (RW+1)'(`CLKD_DIV_OFFSET);
    assign hi_len  = div_len - (div_len >> 1);
    assign cnt_nxt = (cnt_r == div_len - (RW+1)'(1)) ? '0 : cnt_r + (RW+1)'(1);

    // ----------------------------------------
    // Period counter
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_d_r  <= 1'b0;
            idle_r  <= 1'b1;
            cnt_r   <= '0;
            div_out <= 1'b0;
        end
        else if (clk_en)
        begin
            in_d_r <= clk_in;
            if (clr)
            begin
                idle_r  <= 1'b1;
                cnt_r   <= '0;
                div_out <= 1'b0;
            end
            else if (clk_in && !in_d_r)
            begin
                idle_r  <= 1'b0;
                cnt_r   <= idle_r ? '0 : cnt_nxt;
                div_out <= idle_r ? 1'b1 : (cnt_nxt < hi_len);
            end
        end
    end

endmodule : clkd_divider

/* design/clkd_top.sv */
// Clock reference select, prescaler, divider, gating and power-down control
// ----------------------------------------
// Notes on behaviour
// - Gate input high lets the divided clock run freely.
// - Gate low holds divided pin low, at once or at its next fall.
// - While gated off, oscillator keeps running and divider counters are cleared.
// - After gate returns high, first divided edge within one to two master periods.
// - Pin function one and pin low: gate output, then tap, then stop oscillator.
// - Pin function zero: pin high picks internal, pin low picks external reference.
// - Tap carries the reference mux output, ignores gate, stops cleanly at power-down.
// - Tap disable bit at one turns the tap off for good.
// - Settings change only through programming then a later operating power-up.
// - Configuration is a 9-bit mode word and a 9-bit ratio word.
// - With pin function one, reference source bit one picks external, zero picks internal.
// - Bypass-all bit routes master clock straight out, ratio ignored.
// - Bypass-all with internal reference also skips the prescaler.
// - Prescaler bypass bit one skips prescaler, zero inserts it.
// - Prescaler ratio zero divides by four, one divides by two.
// - External reference without bypass-all is divided by ratio only.
// - Divided pin is an output except at power-down and in programming mode, where it takes data.
// - Operating power-up loads stored words before any clock is made.
// - Divider divides by stored ratio plus two, 2 to 513.
// - Tap disable zero drives master clock on tap, one floats it.
// - Gate input is sampled on master clock rises before gating the divider.
// ----------------------------------------
`timescale 1ns/1ps
`include "clkd_params.svh"
module clkd_top #(
    parameter int W = `CLKD_WORD_W
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        nvm_init_b,
    input  wire logic        clk_en,
    input  wire logic        prog_mode_strap,
    input  wire logic        output_gate,
    input  wire logic        dual_use_control_pin,
    input  wire logic        ext_reference_pin,
    input  wire logic        div_clk_pin_in,
    input  wire logic        prog_bit_strobe,
    input  wire logic        prog_write_cmd,
    output logic             div_clk_pin_out,
    output logic             div_clk_pin_oe,
    output logic             reference_clock_tap,
    output logic             reference_clock_tap_oe,
    output clkd_pkg::clkd_cfg_t active_cfg,
    output logic             osc_running,
    output logic             prog_active
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    clkd_pkg::clkd_state_t state_r;
    clkd_pkg::clkd_state_t state_nxt;
    clkd_pkg::clkd_pwr_t   pw_r;
    clkd_pkg::clkd_pwr_t   pw_nxt;
    clkd_pkg::clkd_mode_t  nvm_mode_r;
    logic [W-1:0]          nvm_ratio_r;
    clkd_pkg::clkd_mode_t  mode;
    logic [`CLKD_SHIFT_W-1:0] shift_r;
    logic                  run;
    logic                  pd_req;
    logic                  int_osc_r;
    logic                  ext_lvl_r;
    logic                  pre_out;
    logic                  int_clk;
    logic                  sel_ext_want;
    logic                  sel_ext_r;
    logic                  mclk;
    logic                  mclk_d_r;
    logic                  mclk_rise;
    logic                  gate_smp_r;
    logic                  gate_eff;
    logic                  byp_gate_r;
    logic                  div_out;
    logic                  div_clr;
    logic                  out_nxt;
    logic                  tap_on;

    assign mode        = active_cfg.mode;
    assign run         = (state_r == clkd_pkg::CLKD_ST_RUN);
    assign prog_active = (state_r == clkd_pkg::CLKD_ST_PROG);

    // ----------------------------------------
    // Power-up sequencer
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            clkd_pkg::CLKD_ST_STRAP:
                state_nxt = prog_mode_strap ? clkd_pkg::CLKD_ST_PROG
                                            : clkd_pkg::CLKD_ST_LOAD;
            clkd_pkg::CLKD_ST_LOAD:
                state_nxt = clkd_pkg::CLKD_ST_RUN;
            clkd_pkg::CLKD_ST_PROG:
                state_nxt = clkd_pkg::CLKD_ST_PROG;
            clkd_pkg::CLKD_ST_RUN:
                state_nxt = clkd_pkg::CLKD_ST_RUN;
            default:
                state_nxt = clkd_pkg::CLKD_ST_STRAP;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= clkd_pkg::CLKD_ST_STRAP;
        else if (clk_en)
            state_r <= state_nxt;
    end

    // ----------------------------------------
    // Programming shift path and stored words
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            shift_r <= '0;
        else if (clk_en && prog_active && prog_bit_strobe)
            shift_r <= {shift_r[`CLKD_SHIFT_W-2:0], div_clk_pin_in};
    end

    always_ff @(posedge ref_clk or negedge nvm_init_b)
    begin
        if (!nvm_init_b)
        begin
            nvm_mode_r  <= `CLKD_MODE_DEFAULT;
            nvm_ratio_r <= `CLKD_RATIO_DEFAULT;
        end
        else if (clk_en && prog_active && prog_write_cmd)
        begin
            nvm_mode_r  <= shift_r[`CLKD_SHIFT_W-1:W];
            nvm_ratio_r <= shift_r[W-1:0];
        end
    end

    // ----------------------------------------
    // Working configuration
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            active_cfg <= '0;
        else if (clk_en && state_r == clkd_pkg::CLKD_ST_LOAD)
        begin
            active_cfg.mode           <= nvm_mode_r;
            active_cfg.mode.zero_bits <= 3'h0;
            active_cfg.ratio          <= nvm_ratio_r;
        end
    end

    // ----------------------------------------
    // Power-down sequencer
    // ----------------------------------------
    assign pd_req = run && mode.pin_func && !dual_use_control_pin;

    always_comb
    begin
        pw_nxt = pw_r;
        case (pw_r)
            clkd_pkg::CLKD_PW_ON:
                if (pd_req)
                    pw_nxt = clkd_pkg::CLKD_PW_GATE;
            // Release the pin only with no high phase pending
            clkd_pkg::CLKD_PW_GATE:
                if (!pd_req)
                    pw_nxt = clkd_pkg::CLKD_PW_ON;
                else if (!div_clk_pin_out && !out_nxt)
                    pw_nxt = clkd_pkg::CLKD_PW_TAP;
            clkd_pkg::CLKD_PW_TAP:
                if (!reference_clock_tap && !mclk)
                    pw_nxt = clkd_pkg::CLKD_PW_OFF;
            clkd_pkg::CLKD_PW_OFF:
                if (!pd_req)
                    pw_nxt = clkd_pkg::CLKD_PW_ON;
            default:
                pw_nxt = clkd_pkg::CLKD_PW_ON;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            pw_r <= clkd_pkg::CLKD_PW_ON;
        else if (clk_en)
            pw_r <= pw_nxt;
    end

    assign osc_running = run && (pw_r != clkd_pkg::CLKD_PW_OFF);

    // ----------------------------------------
    // Reference sources
    // ----------------------------------------
    // Internal oscillator, stopped at power-down
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            int_osc_r <= 1'b0;
        else if (clk_en)
            int_osc_r <= osc_running ? ~int_osc_r : 1'b0;
    end

    // External level, parked low at power-down
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            ext_lvl_r <= 1'b0;
        else if (clk_en)
            ext_lvl_r <= osc_running ? ext_reference_pin : 1'b0;
    end

    clkd_prescaler u_pre (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .clk_in  (int_osc_r),
        .div2    (mode.pre_ratio),
        .clk_out (pre_out)
    );

    assign int_clk = (mode.byp_all || mode.pre_byp) ? int_osc_r : pre_out;

    // ----------------------------------------
    // Reference select mux
    // ----------------------------------------
    assign sel_ext_want = mode.pin_func ? mode.ref_src
                                        : !dual_use_control_pin;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            sel_ext_r <= 1'b0;
        else if (clk_en && (state_r == clkd_pkg::CLKD_ST_LOAD))
            sel_ext_r <= nvm_mode_r.pin_func ? nvm_mode_r.ref_src
                                             : !dual_use_control_pin;
        else if (clk_en && !int_clk && !ext_lvl_r)
            sel_ext_r <= sel_ext_want;
    end

    assign mclk = sel_ext_r ? ext_lvl_r : int_clk;

    // ----------------------------------------
    // Gate sampling
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            mclk_d_r <= 1'b0;
        else if (clk_en)
            mclk_d_r <= mclk;
    end

    assign mclk_rise = mclk && !mclk_d_r;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            gate_smp_r <= 1'b0;
        else if (clk_en && mclk_rise)
            gate_smp_r <= output_gate;
    end

    assign gate_eff = gate_smp_r && run && (pw_r == clkd_pkg::CLKD_PW_ON);

    // Bypass gate, changes only while master clock low
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            byp_gate_r <= 1'b0;
        else if (clk_en && !mclk)
            byp_gate_r <= gate_eff;
    end

    // ----------------------------------------
    // Programmable divider
    // ----------------------------------------
    assign div_clr = !run || (!gate_eff && !div_out);

    clkd_divider #(
        .RW (W)
    ) u_div (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .clk_in  (mclk),
        .clr     (div_clr),
        .ratio   (active_cfg.ratio),
        .div_out (div_out)
    );

    // ----------------------------------------
    // Divided output pin
    // ----------------------------------------
    assign out_nxt = mode.byp_all ? (mclk && byp_gate_r)
                                  : div_out;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_clk_pin_out <= 1'b0;
        else if (clk_en)
            div_clk_pin_out <= run ? out_nxt : 1'b0;
    end

    // Pin released in programming mode and power-down
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_clk_pin_oe <= 1'b0;
        else if (clk_en)
            div_clk_pin_oe <= (state_nxt == clkd_pkg::CLKD_ST_LOAD) ||
                              ((state_nxt == clkd_pkg::CLKD_ST_RUN) &&
                               ((pw_nxt == clkd_pkg::CLKD_PW_ON) ||
                                (pw_nxt == clkd_pkg::CLKD_PW_GATE)));
    end

    // ----------------------------------------
    // Reference tap
    // ----------------------------------------
    assign tap_on = run && !mode.tap_dis &&
                    (pw_r != clkd_pkg::CLKD_PW_OFF);

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            reference_clock_tap <= 1'b0;
        else if (clk_en)
            reference_clock_tap <= tap_on && mclk;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            reference_clock_tap_oe <= 1'b0;
        else if (clk_en)
            reference_clock_tap_oe <= tap_on && (pw_nxt != clkd_pkg::CLKD_PW_OFF);
    end

endmodule : clkd_top

/* verification/clkd_top_chk.sv */
// Port assertions for the clock divider control block
`timescale 1ns/1ps
module clkd_top_chk (
    input wire logic                ref_clk,
    input wire logic                rst_b,
    input wire logic                output_gate,
    input wire logic                dual_use_control_pin,
    input wire logic                div_clk_pin_out,
    input wire logic                div_clk_pin_oe,
    input wire logic                reference_clock_tap_oe,
    input wire clkd_pkg::clkd_cfg_t active_cfg,
    input wire logic                osc_running,
    input wire logic                prog_active
);
    logic [7:0] gate_low_cnt_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // Cycles the gate input has been low
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            gate_low_cnt_r <= 8'h00;
        else if (output_gate)
            gate_low_cnt_r <= 8'h00;
        else if (gate_low_cnt_r != 8'hFF)
            gate_low_cnt_r <= gate_low_cnt_r + 8'h01;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_PROG_NO_DRIVE: assert property (prog_active |-> !div_clk_pin_oe)
        else $error("divided pin driven in programming mode");
    AST_TOP_BITS_ZERO: assert property (active_cfg.mode.zero_bits == 3'h0)
        else $error("mode word top bits not zero");
    AST_CFG_FROZEN: assert property ($past(div_clk_pin_oe, 2) && $past(div_clk_pin_oe)
        && div_clk_pin_oe |-> $stable(active_cfg))
        else $error("working configuration changed while running");
    AST_TAP_DISABLED: assert property (active_cfg.mode.tap_dis |-> !reference_clock_tap_oe)
        else $error("tap driven while disabled");
    AST_GATE_HOLD: assert property ((gate_low_cnt_r >= 8'h28) && !div_clk_pin_out
        |=> !div_clk_pin_out)
        else $error("divided pin rose while gated off");
    AST_REENABLE: assert property ($rose(output_gate) && osc_running && div_clk_pin_oe
        |-> ##[1:40] div_clk_pin_out)
        else $error("no divided edge after gate release");
    AST_PWR_DOWN: assert property (!prog_active && active_cfg.mode.pin_func
        && !dual_use_control_pin [*4]
        |-> ##[0:60] (!osc_running && !reference_clock_tap_oe && !div_clk_pin_oe))
        else $error("power-down did not complete");
    AST_PD_ORDER: assert property ($fell(reference_clock_tap_oe) |-> !div_clk_pin_oe)
        else $error("tap released before divided pin");
    AST_OE_DROP_LOW: assert property ($fell(div_clk_pin_oe) |-> !div_clk_pin_out)
        else $error("divided pin released while high");
endmodule : clkd_top_chk

/* verification/clkd_ext_src.sv */
// External reference source model
`timescale 1ns/1ps
module clkd_ext_src #(
    parameter int HALF = 4
) (
    input  wire logic ref_clk,
    input  wire logic run,
    output logic      ext_clk
);
    int cnt;

    initial
    begin
        ext_clk = 1'b0;
        cnt     = 0;
    end

    // Toggles every HALF cycles, parks low when stopped
    always @(posedge ref_clk)
    begin
        #10;
        cnt = (cnt + 1) % HALF;
        if (!run)
            ext_clk = 1'b0;
        else if (cnt == 0)
            ext_clk = ~ext_clk;
    end
endmodule : clkd_ext_src

/* verification/tb.sv */
// Testbench for the clock divider control block
`timescale 1ns/1ps
module tb;
    logic                ref_clk, rst_b, nvm_init_b, clk_en, prog_mode_strap, output_gate;
    logic                dual_use_control_pin, ext_reference_pin, div_clk_pin_in, tp, seen_hi;
    logic                prog_bit_strobe, prog_write_cmd, div_clk_pin_out, div_clk_pin_oe;
    logic                reference_clock_tap, reference_clock_tap_oe, osc_running, prog_active;
    clkd_pkg::clkd_cfg_t active_cfg;
    int                  err_count, comparisons, cyc, n, tog;
    logic [8:0]          mode_tab [8] = '{9'h010, 9'h018, 9'h014, 9'h012,
                                          9'h031, 9'h033, 9'h004, 9'h005};
    logic [8:0]          rat_tab  [8] = '{9'h000, 9'h000, 9'h1FF, 9'h1FF,
                                          9'h001, 9'h0AA, 9'h003, 9'h003};
    logic                dual_tab [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic                tap_tab  [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    int                  per_tab  [8] = '{16, 8, 1026, 2, 24, 8, 40, 10};

    clkd_top u_clkd_top (.ref_clk(ref_clk), .rst_b(rst_b), .nvm_init_b(nvm_init_b),
        .clk_en(clk_en), .prog_mode_strap(prog_mode_strap), .output_gate(output_gate),
        .dual_use_control_pin(dual_use_control_pin), .ext_reference_pin(ext_reference_pin),
        .div_clk_pin_in(div_clk_pin_in), .prog_bit_strobe(prog_bit_strobe),
        .prog_write_cmd(prog_write_cmd), .div_clk_pin_out(div_clk_pin_out),
        .div_clk_pin_oe(div_clk_pin_oe), .reference_clock_tap(reference_clock_tap),
        .reference_clock_tap_oe(reference_clock_tap_oe), .active_cfg(active_cfg),
        .osc_running(osc_running), .prog_active(prog_active));

    clkd_ext_src u_clkd_ext_src (.ref_clk(ref_clk), .run(1'b1), .ext_clk(ext_reference_pin));

    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick();
        @(posedge ref_clk);
        #10;
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic power_up();
        rst_b = 1'b0;
        repeat (8) tick();
        rst_b = 1'b1;
        repeat (4) tick();
    endtask : power_up

    task automatic shift_word(input logic [17:0] w);
        for (int i = 17; i >= 0; i--)
        begin
            div_clk_pin_in  = w[i];
            prog_bit_strobe = 1'b1;
            tick();
        end
        prog_bit_strobe = 1'b0;
        prog_write_cmd  = 1'b1;
        tick();
        prog_write_cmd  = 1'b0;
        tick();
    endtask : shift_word

    task automatic wait_rise(output int cnt);
        logic prev;
        cnt = 0;
        do
        begin
            prev = div_clk_pin_out;
            tick();
            cnt++;
        end while (!(div_clk_pin_out === 1'b1 && prev === 1'b0) && cnt < 2000);
    endtask : wait_rise

    task automatic program_cfg(input logic [8:0] m, input logic [8:0] r, input logic d);
        dual_use_control_pin = 1'b1;
        prog_mode_strap      = 1'b1;
        power_up();
        check(prog_active, 1'b1);
        check(div_clk_pin_oe, 1'b0);
        shift_word({m, r});
        prog_mode_strap      = 1'b0;
        dual_use_control_pin = d;
        power_up();
        check(active_cfg, {m, r});
        check(div_clk_pin_oe, 1'b1);
    endtask : program_cfg

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {rst_b, nvm_init_b, prog_mode_strap, div_clk_pin_in} = 4'h0;
        {prog_bit_strobe, prog_write_cmd} = 2'h0;
        {clk_en, output_gate, dual_use_control_pin} = 3'h7;
        repeat (4) tick();
        nvm_init_b = 1'b1;
        repeat (4) tick();
        rst_b = 1'b1;
        repeat (4) tick();
        check(active_cfg, {9'h010, 9'h000});
        for (int i = 0; i < 8; i++)
        begin
            program_cfg(mode_tab[i], rat_tab[i], dual_tab[i]);
            check(reference_clock_tap_oe, tap_tab[i]);
            wait_rise(n);
            wait_rise(n);
            check(n, per_tab[i]);
        end
        shift_word(18'h3FFFF);
        check(active_cfg, {9'h005, 9'h003});
        power_up();
        check(active_cfg, {9'h005, 9'h003});
        program_cfg(9'h010, 9'h000, 1'b1);
        output_gate = 1'b0;
        repeat (30) tick();
        check(div_clk_pin_out, 1'b0);
        seen_hi = 1'b0;
        tog = 0;
        tp = reference_clock_tap;
        repeat (40)
        begin
            tick();
            if (div_clk_pin_out !== 1'b0)
                seen_hi = 1'b1;
            if (reference_clock_tap !== tp)
                tog++;
            tp = reference_clock_tap;
        end
        check(seen_hi, 1'b0);
        check(osc_running, 1'b1);
        check(tog > 0, 1'b1);
        output_gate = 1'b1;
        wait_rise(n);
        check(n <= 20, 1'b1);
        wait_rise(n);
        check(n, 16);
        dual_use_control_pin = 1'b0;
        repeat (60) tick();
        check({div_clk_pin_oe, reference_clock_tap_oe, osc_running}, 3'h0);
        dual_use_control_pin = 1'b1;
        repeat (60) tick();
        check({div_clk_pin_oe, reference_clock_tap_oe, osc_running}, 3'h7);
        wait_rise(n);
        wait_rise(n);
        check(n, 16);
        clk_en = 1'b0;
        tp = div_clk_pin_out;
        seen_hi = reference_clock_tap;
        repeat (20) tick();
        check({div_clk_pin_out, reference_clock_tap}, {tp, seen_hi});
        check(active_cfg, {9'h010, 9'h000});
        clk_en = 1'b1;
        finish_test();
    end
endmodule : tb

bind clkd_top clkd_top_chk u_clkd_top_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .output_gate(output_gate), .dual_use_control_pin(dual_use_control_pin),
    .div_clk_pin_out(div_clk_pin_out), .div_clk_pin_oe(div_clk_pin_oe),
    .reference_clock_tap_oe(reference_clock_tap_oe), .active_cfg(active_cfg),
    .osc_running(osc_running), .prog_active(prog_active));
